/* File: design/ifr_pkg.sv */
// Shared constants and types for the input function router
package ifr_pkg;

   localparam int IFR_NTERM = 7;
   localparam int IFR_CODE_W = 6;

   // Assignment codes
   localparam logic [5:0] IFR_CODE_NONE = 6'h00;
   localparam logic [5:0] IFR_CODE_FWD = 6'h01;
   localparam logic [5:0] IFR_CODE_REV = 6'h02;
   localparam logic [5:0] IFR_CODE_STOP = 6'h13;
   localparam logic [5:0] IFR_CODE_BRAKE = 6'h14;
   localparam logic [5:0] IFR_CODE_EXTF = 6'h15;
   localparam logic [5:0] IFR_CODE_HEAT = 6'h16;
   localparam logic [5:0] IFR_CODE_ALARM = 6'h18;
   localparam logic [5:0] IFR_CODE_LOCK = 6'h1b;
   localparam logic [5:0] IFR_CODE_GEN0 = 6'h20;
   localparam logic [5:0] IFR_CODE_OPS0 = 6'h30;
   localparam logic [5:0] IFR_CODE_TORQ = 6'h36;

   // Reset values, terminal zero in the lowest slot
   localparam logic [6:0][5:0] IFR_SEL_RST =
      {6'h16, 6'h14, 6'h18, 6'h30, 6'h13, 6'h02, 6'h01};
   localparam logic [6:0] IFR_CFG_RST = 7'h00;
   localparam logic [3:0] IFR_NET_RST = 4'h0;

   // Byte offsets; select register k sits at IFR_OFF_SEL0 + 4*k
   localparam logic [5:0] IFR_OFF_SEL0 = 6'h00;
   localparam logic [5:0] IFR_OFF_CFG = 6'h1c;
   localparam logic [5:0] IFR_OFF_NET = 6'h20;
   localparam logic [5:0] IFR_OFF_PIN = 6'h24;
   localparam logic [5:0] IFR_OFF_FUNC = 6'h28;

   // Network source register fields
   localparam int IFR_NET_LOCK_EN = 0;
   localparam int IFR_NET_LOCK_VAL = 1;
   localparam int IFR_NET_TORQ_EN = 2;
   localparam int IFR_NET_TORQ_VAL = 3;

   // Pin status register fields
   localparam int IFR_PIN_RAW = 0;
   localparam int IFR_PIN_ACT = 8;
   localparam int IFR_PIN_TEST = 16;

   typedef struct packed {
      logic [15:0] general_bits;
      logic [3:0] op_select;
      logic test_halt;
      logic torque_cap_disable;
      logic tool_lock_release;
      logic alarm_clear;
      logic overheat_halt;
      logic external_fault;
      logic brake_release;
      logic stop_mode;
      logic backward_run;
      logic forward_run;
   } ifr_func_t;

endpackage : ifr_pkg

/* File: design/ifr_router.sv */
// Input terminal to internal function router with Avalon-MM registers
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module ifr_router #(
   parameter int NTERM = ifr_pkg::IFR_NTERM
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [NTERM-1:0] term_in,
   input wire logic test_mode_in,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output var ifr_pkg::ifr_func_t func_out
);

   // The checks below look at terminals zero and three
   if (NTERM < 4 || NTERM > ifr_pkg::IFR_NTERM) begin : g_bad_nterm
      $error("NTERM must lie between 4 and 7");
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [NTERM-1:0] term_meta;
   logic [NTERM-1:0] term_sync;
   logic test_meta;
   logic test_sync;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         term_meta <= '0;
         term_sync <= '0;
         test_meta <= 1'b0;
         test_sync <= 1'b0;
      end else begin
         term_meta <= term_in;
         term_sync <= term_meta;
         test_meta <= test_mode_in;
         test_sync <= test_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file

   logic [NTERM-1:0][5:0] sel;
   logic [NTERM-1:0] contact_cfg;
   logic [3:0] net_src;
   logic wait_q;

   // Request is answered one cycle after it is first seen
   wire req = avs_read | avs_write;
   wire accept = req & ~wait_q;
   wire wr_now = accept & avs_write;
   wire [3:0] word_idx = avs_address[5:2];
   wire is_sel = (word_idx < 4'(NTERM));
   wire is_cfg = (avs_address == ifr_pkg::IFR_OFF_CFG);
   wire is_net = (avs_address == ifr_pkg::IFR_OFF_NET);
   wire is_pin = (avs_address == ifr_pkg::IFR_OFF_PIN);
   wire is_func = (avs_address == ifr_pkg::IFR_OFF_FUNC);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~(req & wait_q);
      end
   end

   genvar gk;
   generate
      for (gk = 0; gk < NTERM; gk++) begin : g_sel
         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               sel[gk] <= ifr_pkg::IFR_SEL_RST[gk];
            end else if (wr_now && is_sel && word_idx == 4'(gk)) begin
               sel[gk] <= avs_writedata[5:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         contact_cfg <= ifr_pkg::IFR_CFG_RST[NTERM-1:0];
         net_src <= ifr_pkg::IFR_NET_RST;
      end else if (wr_now && is_cfg) begin
         contact_cfg <= avs_writedata[NTERM-1:0];
      end else if (wr_now && is_net) begin
         net_src <= avs_writedata[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Routing

   // Sense inversion first so duplicates combine on true function levels
   wire [NTERM-1:0] act = term_sync ^ contact_cfg;

   function automatic logic any_on(input logic [NTERM-1:0][5:0] s,
                                   input logic [NTERM-1:0] a,
                                   input logic [5:0] c);
      any_on = 1'b0;
      for (int i = 0; i < NTERM; i++) begin
         if (s[i] == c && a[i]) begin
            any_on = 1'b1;
         end
      end
   endfunction : any_on

   function automatic logic is_used(input logic [NTERM-1:0][5:0] s,
                                    input logic [5:0] c);
      is_used = 1'b0;
      for (int i = 0; i < NTERM; i++) begin
         if (s[i] == c) begin
            is_used = 1'b1;
         end
      end
   endfunction : is_used

   function automatic logic all_on(input logic [NTERM-1:0][5:0] s,
                                   input logic [NTERM-1:0] a,
                                   input logic [5:0] c);
      all_on = 1'b1;
      for (int i = 0; i < NTERM; i++) begin
         if (s[i] == c && !a[i]) begin
            all_on = 1'b0;
         end
      end
   endfunction : all_on

   // Code zero matches no function code, so unused terminals fall out
   wire fwd_lvl = any_on(sel, act, ifr_pkg::IFR_CODE_FWD);
   wire rev_lvl = any_on(sel, act, ifr_pkg::IFR_CODE_REV);
   wire stop_lvl = any_on(sel, act, ifr_pkg::IFR_CODE_STOP);
   wire brake_lvl = any_on(sel, act, ifr_pkg::IFR_CODE_BRAKE);
   wire alarm_lvl = any_on(sel, act, ifr_pkg::IFR_CODE_ALARM);

   // Normally closed stops: halt while assigned and no terminal is on
   wire heat_halt = is_used(sel, ifr_pkg::IFR_CODE_HEAT) &
      ~any_on(sel, act, ifr_pkg::IFR_CODE_HEAT);
   wire extf_halt = is_used(sel, ifr_pkg::IFR_CODE_EXTF) &
      ~any_on(sel, act, ifr_pkg::IFR_CODE_EXTF);

   // Tool lock and torque cap: AND of every source, ON when none
   wire lock_dir = is_used(sel, ifr_pkg::IFR_CODE_LOCK);
   wire lock_net = net_src[ifr_pkg::IFR_NET_LOCK_EN];
   wire lock_lvl = (~lock_dir | all_on(sel, act, ifr_pkg::IFR_CODE_LOCK))
      & (~lock_net | net_src[ifr_pkg::IFR_NET_LOCK_VAL]);
   wire torq_dir = is_used(sel, ifr_pkg::IFR_CODE_TORQ);
   wire torq_net = net_src[ifr_pkg::IFR_NET_TORQ_EN];
   wire torq_lvl = (~torq_dir | all_on(sel, act, ifr_pkg::IFR_CODE_TORQ))
      & (~torq_net | net_src[ifr_pkg::IFR_NET_TORQ_VAL]);
   // With no source at all both terms above reduce to one
   wire lock_free = ~lock_dir & ~lock_net;
   wire torq_free = ~torq_dir & ~torq_net;

   logic [15:0] gen_lvl;
   logic [3:0] ops_lvl;
   genvar gj;
   generate
      for (gj = 0; gj < 16; gj++) begin : g_gen
         assign gen_lvl[gj] = any_on(sel, act,
            ifr_pkg::IFR_CODE_GEN0 + 6'(gj));
      end
      for (gj = 0; gj < 4; gj++) begin : g_ops
         assign ops_lvl[gj] = any_on(sel, act,
            ifr_pkg::IFR_CODE_OPS0 + 6'(gj));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Alarm clear edge and test mode halt

   logic alarm_prev;
   logic halt_q;

   wire alarm_fall = alarm_prev & ~alarm_lvl;
   // Set wins over clear; clearing needs test, forward and reverse all off
   wire next_halt = (test_sync & (fwd_lvl | rev_lvl)) |
      (halt_q & (test_sync | fwd_lvl | rev_lvl));

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         alarm_prev <= 1'b0;
         halt_q <= 1'b0;
      end else begin
         alarm_prev <= alarm_lvl;
         halt_q <= next_halt;
      end
   end

   ifr_pkg::ifr_func_t next_func;

   always_comb begin
      next_func = '0;
      next_func.forward_run = fwd_lvl;
      next_func.backward_run = rev_lvl;
      next_func.stop_mode = stop_lvl;
      next_func.brake_release = brake_lvl;
      next_func.external_fault = extf_halt;
      next_func.overheat_halt = heat_halt;
      next_func.alarm_clear = alarm_fall;
      next_func.tool_lock_release = lock_lvl | lock_free;
      next_func.torque_cap_disable = torq_lvl | torq_free;
      next_func.test_halt = next_halt;
      next_func.op_select = ops_lvl;
      next_func.general_bits = gen_lvl;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         func_out <= '0;
      end else begin
         func_out <= next_func;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; select words decode on address bits 5:2 only, other unmapped addresses read zero

   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      if (is_sel) begin
         next_rdata[5:0] = sel[word_idx[2:0]];
      end else if (is_cfg) begin
         next_rdata[NTERM-1:0] = contact_cfg;
      end else if (is_net) begin
         next_rdata[3:0] = net_src;
      end else if (is_pin) begin
         next_rdata[ifr_pkg::IFR_PIN_RAW +: NTERM] = term_sync;
         next_rdata[ifr_pkg::IFR_PIN_ACT +: NTERM] = act;
         next_rdata[ifr_pkg::IFR_PIN_TEST] = test_sync;
      end else if (is_func) begin
         next_rdata[$bits(ifr_pkg::ifr_func_t)-1:0] = func_out;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= '0;
      end else if (avs_read && wait_q) begin
         avs_readdata <= next_rdata;
      end
   end

   assign avs_waitrequest = wait_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_alarm_fall;
      alarm_lvl ##1 !alarm_lvl;
   endsequence

   sequence s_test_run;
      test_sync && (fwd_lvl || rev_lvl);
   endsequence

   chk_sel_write: assert property (
      wr_now && word_idx == 4'h0 |=> sel[0] == $past(avs_writedata[5:0]))
      else $error("select write not stored");

   chk_unused_idle: assert property (
      !is_used(sel, ifr_pkg::IFR_CODE_FWD) |=> !func_out.forward_run)
      else $error("forward run without assigned terminal");

   chk_fwd_route: assert property (
      sel[0] == ifr_pkg::IFR_CODE_FWD && act[0] |=> func_out.forward_run)
      else $error("forward run not routed");

   chk_contact_invert: assert property (
      sel[0] == ifr_pkg::IFR_CODE_FWD && contact_cfg[0] && !term_sync[0]
      |=> func_out.forward_run)
      else $error("normally closed sense not inverted");

   chk_alarm_edge: assert property (
      s_alarm_fall |=> func_out.alarm_clear)
      else $error("alarm clear missed on falling edge");

   chk_alarm_only_fall: assert property (
      func_out.alarm_clear |-> $past(alarm_prev) && !$past(alarm_lvl))
      else $error("alarm clear without falling edge");

   chk_lock_default: assert property (
      lock_free |=> func_out.tool_lock_release)
      else $error("unassigned tool lock release not on");

   chk_torque_all: assert property (
      torq_net && !net_src[ifr_pkg::IFR_NET_TORQ_VAL]
      |=> !func_out.torque_cap_disable)
      else $error("torque cap disable with a source off");

   chk_test_halt: assert property (
      (s_test_run or (halt_q && (test_sync || fwd_lvl || rev_lvl)))
      |=> func_out.test_halt)
      else $error("test halt not raised or not held");

   chk_op_route: assert property (
      sel[3] == ifr_pkg::IFR_CODE_OPS0 && act[3]
      |=> func_out.op_select[0])
      else $error("operation select bit not routed");

   chk_bus_answer: assert property (
      req && wait_q |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle");

endmodule : ifr_router

`default_nettype wire

/* File: verif/ifr_switch_bank.sv */
// Behavioural bank of field switches feeding the input terminals
`timescale 1ns/1ns
`default_nettype none

module ifr_switch_bank (
   input wire logic ref_clk,
   input wire logic [6:0] want_term,
   input wire logic want_test,
   output logic [6:0] term_out,
   output logic test_out
);
   // Contacts move on a clock edge, so the sync flops see clean changes
   always_ff @(posedge ref_clk) begin
      term_out <= want_term;
      test_out <= want_test;
   end
endmodule : ifr_switch_bank

`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the input function router
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic ref_clk = 0, nrst = 0, avs_read = 0, avs_write = 0, want_test = 0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, rd;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, test_mode_in;
   logic [6:0] want_term = 7'h00, term_in;
   ifr_pkg::ifr_func_t func_out, base;
   int fail_count = 0, total_checks = 0;

   ifr_switch_bank i_sw (.ref_clk(ref_clk), .want_term(want_term),
      .want_test(want_test), .term_out(term_in), .test_out(test_mode_in));
   ifr_router i_dut (.ref_clk(ref_clk), .nrst(nrst), .term_in(term_in),
      .test_mode_in(test_mode_in), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .func_out(func_out));

   initial begin
      forever #4 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input string nm, input logic [31:0] exp,
                        input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   // One access; the request stands until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      // Only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic sel(input int k, input logic [5:0] c);
      bus(1'b1, 6'(4 * k), {26'h0, c});
   endtask : sel

   // Pins reach func_out three edges after the switch bank moves
   task automatic pins(input logic [6:0] t, input logic tm);
      @(posedge ref_clk);
      want_term <= t;
      want_test <= tm;
      repeat (6) @(posedge ref_clk);
   endtask : pins

   task automatic fcheck(input string nm, input ifr_pkg::ifr_func_t e);
      check(nm, {2'b00, e}, {2'b00, func_out});
   endtask : fcheck

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values;
      for (int k = 0; k < 7; k++) begin
         bus(1'b0, 6'(4 * k), 32'h0);
         check("select reset", {26'h0, ifr_pkg::IFR_SEL_RST[k]}, rd);
      end
      bus(1'b0, ifr_pkg::IFR_OFF_CFG, 32'h0);
      check("contact reset", 32'h0, rd);
      bus(1'b0, 6'h2c, 32'h0);
      check("unmapped read", 32'h0, rd);
      for (int k = 0; k < 7; k++) sel(k, ifr_pkg::IFR_CODE_NONE);
      pins(7'h7f, 1'b0);
      fcheck("all unused", base);
   endtask : t_reset_values

   task automatic t_code_table;
      logic [5:0] codes [8];
      int bits [8];
      ifr_pkg::ifr_func_t e;
      codes = '{6'h01, 6'h02, 6'h13, 6'h14, 6'h20, 6'h2f, 6'h30, 6'h33};
      bits = '{0, 1, 2, 3, 14, 29, 10, 13};
      for (int i = 0; i < 8; i++) begin
         sel(0, codes[i]);
         pins(7'h01, 1'b0);
         e = base;
         e[bits[i]] = 1'b1;
         fcheck("code on", e);
         pins(7'h00, 1'b0);
         fcheck("code off", base);
      end
   endtask : t_code_table

   task automatic t_dup_and_invert;
      ifr_pkg::ifr_func_t e;
      sel(1, ifr_pkg::IFR_CODE_FWD);
      sel(0, ifr_pkg::IFR_CODE_FWD);
      pins(7'h02, 1'b0);
      e = base;
      e.forward_run = 1'b1;
      fcheck("duplicate or", e);
      sel(1, ifr_pkg::IFR_CODE_NONE);
      bus(1'b1, ifr_pkg::IFR_OFF_CFG, 32'h1);
      pins(7'h00, 1'b0);
      fcheck("inverted contact", e);
      bus(1'b0, ifr_pkg::IFR_OFF_PIN, 32'h0);
      check("pin status", 32'h100, rd);
      pins(7'h01, 1'b0);
      fcheck("inverted released", base);
      bus(1'b1, ifr_pkg::IFR_OFF_CFG, 32'h0);
      sel(0, ifr_pkg::IFR_CODE_HEAT);
      pins(7'h00, 1'b0);
      e = base;
      e.overheat_halt = 1'b1;
      fcheck("stop input open", e);
      pins(7'h01, 1'b0);
      fcheck("stop input closed", base);
      sel(0, ifr_pkg::IFR_CODE_EXTF);
      pins(7'h00, 1'b0);
      e = base;
      e.external_fault = 1'b1;
      fcheck("fault input open", e);
      pins(7'h01, 1'b0);
      fcheck("fault input closed", base);
   endtask : t_dup_and_invert

   task automatic t_all_sources(input logic [5:0] c, input int b,
                                input logic [31:0] net);
      ifr_pkg::ifr_func_t e;
      sel(0, c);
      sel(1, c);
      pins(7'h01, 1'b0);
      e = base;
      e[b] = 1'b0;
      fcheck("one source off", e);
      pins(7'h03, 1'b0);
      fcheck("all sources on", base);
      bus(1'b1, ifr_pkg::IFR_OFF_NET, net);
      repeat (2) @(posedge ref_clk);
      fcheck("network source off", e);
      bus(1'b0, ifr_pkg::IFR_OFF_NET, 32'h0);
      check("network readback", net, rd);
      bus(1'b1, ifr_pkg::IFR_OFF_NET, 32'h0);
      sel(0, ifr_pkg::IFR_CODE_NONE);
      sel(1, ifr_pkg::IFR_CODE_NONE);
      pins(7'h00, 1'b0);
   endtask : t_all_sources

   task automatic t_alarm_clear;
      int hits;
      sel(0, ifr_pkg::IFR_CODE_ALARM);
      @(posedge ref_clk);
      want_term <= 7'h01;
      hits = 0;
      repeat (8) begin
         @(posedge ref_clk);
         if (func_out.alarm_clear === 1'b1) hits++;
      end
      check("clear on press", 32'h0, 32'(hits));
      want_term <= 7'h00;
      hits = 0;
      repeat (8) begin
         @(posedge ref_clk);
         if (func_out.alarm_clear === 1'b1) hits++;
      end
      check("clear on release", 32'h1, 32'(hits));
   endtask : t_alarm_clear

   task automatic t_test_halt;
      ifr_pkg::ifr_func_t e;
      sel(0, ifr_pkg::IFR_CODE_FWD);
      pins(7'h01, 1'b1);
      e = base;
      e.forward_run = 1'b1;
      e.test_halt = 1'b1;
      fcheck("run in test", e);
      pins(7'h00, 1'b1);
      e.forward_run = 1'b0;
      fcheck("halt held", e);
      bus(1'b0, ifr_pkg::IFR_OFF_FUNC, 32'h0);
      check("function status", {2'b00, e}, rd);
      pins(7'h00, 1'b0);
      fcheck("halt cleared", base);
   endtask : t_test_halt

   ////////////////////////////////////////////////////////////////////////
   initial begin
      base = '0;
      base.tool_lock_release = 1'b1;
      base.torque_cap_disable = 1'b1;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset_values();
      t_code_table();
      t_dup_and_invert();
      t_all_sources(ifr_pkg::IFR_CODE_LOCK, 7, 32'h1);
      t_all_sources(ifr_pkg::IFR_CODE_TORQ, 8, 32'h4);
      t_alarm_clear();
      t_test_halt();
      print_verdict();
   end

   // Whole run needs well under 2000 cycles
   initial begin
      #80000;
      fail_count++;
      print_verdict();
   end
endmodule : tb

`default_nettype wire
